/* File: rtl/clkd_ctrl.v */
// Serial control port engine and control register outputs of the clock distributor
`timescale 1ns/100ps
`default_nettype none
`include "clkd_consts.vh"
module clkd_ctrl
(
	// Clock, reset, enable
	input  wire       clk_in,
	input  wire       nrst_in,
	input  wire       ce_in,
	// Serial control port
	input  wire       sclk_in,
	input  wire       cs_n_in,
	input  wire       sdio_in,
	output wire       sdio_out,
	output wire       sdio_oe_out,
	output wire       serial_out_pin_out,
	output wire       serial_out_pin_oe_out,
	// Port configuration state
	output wire       soft_reset_out,
	output wire       long_instr_out,
	output wire       lsb_first_out,
	// Adjustable delay output
	output wire       adjustable_delay_output_bypass_out,
	output wire [2:0] ramp_current_out,
	output wire [2:0] ramp_capacitor_out,
	// Divider controls
	output wire [7:0] div2_phase_out,
	output wire [7:0] div3_counts_out,
	output wire [7:0] div3_phase_out,
	output wire [7:0] div4_counts_out,
	output wire [7:0] div4_phase_out,
	// Function pin and sync
	output wire       power_down_all_reference_out,
	output wire [2:0] sync_cfg_out
);
	localparam [3:0] ST_IDLE  = 4'b0001;
	localparam [3:0] ST_INSTR = 4'b0010;
	localparam [3:0] ST_DATA  = 4'b0100;
	localparam [3:0] ST_WAIT  = 4'b1000;

	reg  [3:0]  state_q;
	reg         sclk_q;
	reg  [3:0]  cnt_q;
	reg  [15:0] ishift_q;
	reg  [7:0]  dshift_q;
	reg  [7:0]  out_q;
	reg         sdo_q;
	reg         rw_q;
	reg  [1:0]  left_q;
	reg         stream_q;
	reg  [12:0] addr_q;

	// One step of the instruction shifter in either bit order
	function [15:0] clkd_shift16;
		input [15:0] v;
		input        lsb;
		input        b;
		begin
			if (lsb)
				clkd_shift16 = {b, v[15:1]};
			else
				clkd_shift16 = {v[14:0], b};
		end
	endfunction

	// One step of a byte shifter, shared by receive and transmit
	function [7:0] clkd_shift8;
		input [7:0] v;
		input       lsb;
		input       b;
		begin
			if (lsb)
				clkd_shift8 = {b, v[7:1]};
			else
				clkd_shift8 = {v[6:0], b};
		end
	endfunction

	wire [71:0] act_w;
	wire [7:0]  rd_data_w;
	wire [7:0]  cfg_w     = act_w[7:0];
	wire        lsb_w     = cfg_w[`CLKD_CFG_LSB];
	wire        long_w    = cfg_w[`CLKD_CFG_LONG];
	wire        bidir_w   = cfg_w[`CLKD_CFG_BIDIR];
	wire        rise_w    = sclk_in & ~sclk_q;
	wire        fall_w    = ~sclk_in & sclk_q;

	// Bit order also governs the instruction phase
	wire [15:0] inx_w = clkd_shift16(ishift_q, lsb_w, sdio_in);
	wire [7:0]  dnx_w = clkd_shift8(dshift_q, lsb_w, sdio_in);
	wire [7:0]  short_w = lsb_w ? inx_w[15:8] : inx_w[7:0];
	wire        dec_rw_w   = long_w ? inx_w[15] : short_w[7];
	wire [1:0]  dec_len_w  = long_w ? inx_w[14:13] : short_w[6:5];
	wire [12:0] dec_addr_w = long_w ? inx_w[12:0] : {8'h00, short_w[4:0]};
	wire [3:0]  ilast_w    = long_w ? 4'hF : 4'h7;
	wire [12:0] next_addr_w = lsb_w ? addr_q + 13'h0001 : addr_q - 13'h0001;
	wire        ilast_hit_w = (state_q == ST_INSTR) && rise_w && (cnt_q == ilast_w);
	wire        byte_hit_w  = (state_q == ST_DATA) && rise_w && (cnt_q == 4'h7);
	wire        wr_en_w     = ce_in && byte_hit_w && !rw_q;
	wire [12:0] rd_addr_w   = (state_q == ST_INSTR) ? dec_addr_w : next_addr_w;

	clkd_regfile u_regs
	(
		.clk_in     (clk_in),
		.nrst_in    (nrst_in),
		.ce_in      (ce_in),
		.wr_en_in   (wr_en_w),
		.wr_addr_in (addr_q),
		.wr_data_in (dnx_w),
		.rd_addr_in (rd_addr_w),
		.rd_data_out(rd_data_w),
		.act_out    (act_w)
	);

	always @(posedge clk_in)
	begin
		if (!nrst_in)
		begin
			state_q  <= ST_IDLE;
			sclk_q   <= 1'b0;
			cnt_q    <= 4'h0;
			ishift_q <= 16'h0000;
			dshift_q <= 8'h00;
			out_q    <= 8'h00;
			sdo_q    <= 1'b0;
			rw_q     <= 1'b0;
			left_q   <= 2'h0;
			stream_q <= 1'b0;
			addr_q   <= 13'h0000;
		end
		else if (ce_in)
		begin
			sclk_q <= sclk_in;
			if (cs_n_in)
			begin
				state_q <= ST_IDLE;
				cnt_q   <= 4'h0;
			end
			else
			begin
				case (state_q)
					ST_IDLE:
					begin
						state_q <= ST_INSTR;
						cnt_q   <= 4'h0;
						if (rise_w)
						begin
							ishift_q <= inx_w;
							cnt_q    <= 4'h1;
						end
					end
					ST_INSTR:
					begin
						if (rise_w)
						begin
							ishift_q <= inx_w;
							cnt_q    <= cnt_q + 4'h1;
							if (ilast_hit_w)
							begin
								state_q  <= ST_DATA;
								cnt_q    <= 4'h0;
								rw_q     <= dec_rw_w;
								left_q   <= dec_len_w;
								stream_q <= (dec_len_w == 2'h3);
								addr_q   <= dec_addr_w;
								out_q    <= rd_data_w;
							end
						end
					end
					ST_DATA:
					begin
						if (rise_w)
						begin
							dshift_q <= dnx_w;
							cnt_q    <= cnt_q + 4'h1;
							if (byte_hit_w)
							begin
								cnt_q  <= 4'h0;
								addr_q <= next_addr_w;
								out_q  <= rd_data_w;
								left_q <= left_q - 2'h1;
								if (!stream_q && (left_q == 2'h0))
									state_q <= ST_WAIT;
							end
						end
						else if (fall_w && rw_q)
						begin
							sdo_q <= lsb_w ? out_q[0] : out_q[7];
							out_q <= clkd_shift8(out_q, lsb_w, 1'b0);
						end
					end
					ST_WAIT:
					begin
						state_q <= ST_WAIT;
					end
					default:
					begin
						state_q <= ST_IDLE;
					end
				endcase
			end
		end
	end

	// Bidirectional mode turns the data pin round only for read data
	assign sdio_out              = sdo_q;
	assign sdio_oe_out           = bidir_w && rw_q && (state_q == ST_DATA) && !cs_n_in;
	assign serial_out_pin_out    = sdo_q;
	assign serial_out_pin_oe_out = !bidir_w && !cs_n_in;

	assign soft_reset_out   = cfg_w[`CLKD_CFG_SOFT];
	assign long_instr_out   = long_w;
	assign lsb_first_out    = lsb_w;

	// Settings below move only on an update strobe or a soft reset
	assign adjustable_delay_output_bypass_out = act_w[8];
	assign ramp_current_out   = act_w[18:16];
	assign ramp_capacitor_out = act_w[21:19];
	assign div2_phase_out     = act_w[31:24];
	assign div3_counts_out    = act_w[39:32];
	assign div3_phase_out     = act_w[47:40];
	assign div4_counts_out    = act_w[55:48];
	assign div4_phase_out     = act_w[63:56];
	assign power_down_all_reference_out = act_w[67];
	assign sync_cfg_out       = act_w[66:64];
endmodule
`default_nettype wire

/* File: rtl/clkd_consts.vh */
// Register offsets, fields and defaults of the clock distribution control bank
//
// Contract
// - Port configuration writes take effect at once, without the update strobe.
// - Bit 4 of port configuration selects long instruction; resets to 1.
// - Soft reset bit 5 restores defaults of all registers but port configuration and stays set.
// - Bit 6 set: LSB first, address increments; clear: MSB first, decrements.
// - Ramp current field bits 2:0 of ramp register sets delay ramp rate.
// - Update bit 0 copies pending settings into effect, clears itself, resets 0.
`ifndef CLKD_CONSTS_VH
`define CLKD_CONSTS_VH

`define CLKD_A_CFG        13'h0000
`define CLKD_A_DLY_BYP    13'h0034
`define CLKD_A_DLY_RAMP   13'h0035
`define CLKD_A_DIV2_PH    13'h004F
`define CLKD_A_DIV3_CNT   13'h0050
`define CLKD_A_DIV3_PH    13'h0051
`define CLKD_A_DIV4_CNT   13'h0052
`define CLKD_A_DIV4_PH    13'h0053
`define CLKD_A_FUNC       13'h0058
`define CLKD_A_UPDATE     13'h005A

`define CLKD_CFG_LONG     4
`define CLKD_CFG_SOFT     5
`define CLKD_CFG_LSB      6
`define CLKD_CFG_BIDIR    7
`define CLKD_UPD_BIT      0

`define CLKD_RST_CFG      8'h10
`define CLKD_RST_DLY_BYP  8'h01
`define CLKD_RST_DLY_RAMP 8'h00
`define CLKD_RST_DIV2_PH  8'h00
`define CLKD_RST_DIV3_CNT 8'h00
`define CLKD_RST_DIV3_PH  8'h00
`define CLKD_RST_DIV4_CNT 8'h11
`define CLKD_RST_DIV4_PH  8'h00
`define CLKD_RST_FUNC     8'h00

`define CLKD_NREG         9
`define CLKD_IDX_NONE     4'hF

`endif

/* File: rtl/clkd_regfile.v */
// Pending and active register copies with update strobe and soft reset
`timescale 1ns/100ps
`default_nettype none
`include "clkd_consts.vh"
module clkd_regfile
(
	// Clock and reset
	input  wire        clk_in,
	input  wire        nrst_in,
	input  wire        ce_in,
	// Write and read port
	input  wire        wr_en_in,
	input  wire [12:0] wr_addr_in,
	input  wire [7:0]  wr_data_in,
	input  wire [12:0] rd_addr_in,
	output reg  [7:0]  rd_data_out,
	// Active settings, register index order
	output wire [71:0] act_out
);
	reg [7:0] shd_q [0:8];
	reg [7:0] act_q [0:8];
	integer   i;

	function [3:0] clkd_idx;
		input [12:0] a;
		begin
			case (a)
				`CLKD_A_CFG:      clkd_idx = 4'h0;
				`CLKD_A_DLY_BYP:  clkd_idx = 4'h1;
				`CLKD_A_DLY_RAMP: clkd_idx = 4'h2;
				`CLKD_A_DIV2_PH:  clkd_idx = 4'h3;
				`CLKD_A_DIV3_CNT: clkd_idx = 4'h4;
				`CLKD_A_DIV3_PH:  clkd_idx = 4'h5;
				`CLKD_A_DIV4_CNT: clkd_idx = 4'h6;
				`CLKD_A_DIV4_PH:  clkd_idx = 4'h7;
				`CLKD_A_FUNC:     clkd_idx = 4'h8;
				default:          clkd_idx = `CLKD_IDX_NONE;
			endcase
		end
	endfunction

	function [7:0] clkd_dflt;
		input integer k;
		begin
			case (k)
				0:       clkd_dflt = `CLKD_RST_CFG;
				1:       clkd_dflt = `CLKD_RST_DLY_BYP;
				2:       clkd_dflt = `CLKD_RST_DLY_RAMP;
				3:       clkd_dflt = `CLKD_RST_DIV2_PH;
				4:       clkd_dflt = `CLKD_RST_DIV3_CNT;
				5:       clkd_dflt = `CLKD_RST_DIV3_PH;
				6:       clkd_dflt = `CLKD_RST_DIV4_CNT;
				7:       clkd_dflt = `CLKD_RST_DIV4_PH;
				default: clkd_dflt = `CLKD_RST_FUNC;
			endcase
		end
	endfunction

	wire [3:0] wr_idx = clkd_idx(wr_addr_in);
	wire [3:0] rd_idx = clkd_idx(rd_addr_in);
	wire       soft_w = act_q[0][`CLKD_CFG_SOFT];
	wire       upd_w  = wr_en_in && (wr_addr_in == `CLKD_A_UPDATE) && wr_data_in[`CLKD_UPD_BIT];

	always @(posedge clk_in)
	begin
		if (!nrst_in)
		begin
			for (i = 0; i < `CLKD_NREG; i = i + 1)
			begin
				shd_q[i] <= clkd_dflt(i);
				act_q[i] <= clkd_dflt(i);
			end
		end
		else if (ce_in)
		begin
			for (i = 1; i < `CLKD_NREG; i = i + 1)
			begin
				if (soft_w)
				begin
					// Held at defaults for as long as the bit stays set
					shd_q[i] <= clkd_dflt(i);
					act_q[i] <= clkd_dflt(i);
				end
				else
				begin
					if (wr_en_in && (wr_idx == i[3:0]))
						shd_q[i] <= wr_data_in;
					if (upd_w)
						act_q[i] <= shd_q[i];
				end
			end
			if (wr_en_in && (wr_idx == 4'h0))
			begin
				shd_q[0] <= wr_data_in;
				act_q[0] <= wr_data_in;
			end
		end
	end

	// Update register never stores, so it always reads back 0
	always @*
	begin
		if (rd_idx == `CLKD_IDX_NONE)
			rd_data_out = 8'h00;
		else
			rd_data_out = shd_q[rd_idx];
	end

	genvar g;
	generate
		for (g = 0; g < `CLKD_NREG; g = g + 1)
		begin : g_act
			assign act_out[8*g+7:8*g] = act_q[g];
		end
	endgenerate
endmodule
`default_nettype wire

/* File: tb/clkd_ctrl_properties.sv */
// Port-level checker for the control port engine
`timescale 1ns/100ps
`default_nettype none
module clkd_ctrl_properties
(
	// Clock and reset
	input wire logic       clk_in,
	input wire logic       nrst_in,
	// Serial port
	input wire logic       sclk_in,
	input wire logic       cs_n_in,
	input wire logic       sdio_out,
	input wire logic       sdio_oe_out,
	input wire logic       serial_out_pin_oe_out,
	// Control state
	input wire logic       soft_reset_out,
	input wire logic       long_instr_out,
	input wire logic       lsb_first_out,
	input wire logic       adjustable_delay_output_bypass_out,
	input wire logic [2:0] ramp_current_out,
	input wire logic [7:0] div4_counts_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!nrst_in);
	a_reset_values: assert property ($rose(nrst_in) |-> long_instr_out && !soft_reset_out
		&& !lsb_first_out && adjustable_delay_output_bypass_out && div4_counts_out == 8'h11)
		else $error("outputs off default after reset");
	a_out_pin_cs: assert property (serial_out_pin_oe_out |-> !cs_n_in)
		else $error("serial out driven while deselected");
	a_oe_exclusive: assert property (!(sdio_oe_out && serial_out_pin_oe_out))
		else $error("both read pins driven");
	a_data_pin_cs: assert property (sdio_oe_out |-> !cs_n_in)
		else $error("data pin driven while deselected");
	a_soft_defaults: assert property (soft_reset_out [*3] |-> div4_counts_out == 8'h11
		&& ramp_current_out == 3'h0 && adjustable_delay_output_bypass_out)
		else $error("soft reset left settings off default");
	a_soft_stays: assert property (soft_reset_out && cs_n_in |=> soft_reset_out)
		else $error("soft reset bit cleared itself");
	a_cfg_quiet: assert property (cs_n_in && $past(cs_n_in)
		|-> $stable({soft_reset_out, long_instr_out, lsb_first_out}))
		else $error("port config changed without a frame");
	a_active_quiet: assert property (cs_n_in && $past(cs_n_in) && !soft_reset_out
		|-> $stable({ramp_current_out, div4_counts_out, adjustable_delay_output_bypass_out}))
		else $error("active settings changed without a frame");
	a_read_bit_holds: assert property ((!cs_n_in && sclk_in) [*3] |-> $stable(sdio_out))
		else $error("read bit moved while clock high");
	a_read_edge: assert property ($changed(sdio_out) |-> !$past(sclk_in) && $past(sclk_in, 2))
		else $error("read bit moved off a clock fall");
	c_soft: cover property (soft_reset_out && cs_n_in);
	c_bidir: cover property (sdio_oe_out);
	c_update: cover property ($changed(ramp_current_out));
	c_lsb: cover property (lsb_first_out && !cs_n_in);
endmodule
bind clkd_ctrl clkd_ctrl_properties u_props (.clk_in, .nrst_in, .sclk_in, .cs_n_in, .sdio_out,
	.sdio_oe_out, .serial_out_pin_oe_out, .soft_reset_out, .long_instr_out, .lsb_first_out,
	.adjustable_delay_output_bypass_out, .ramp_current_out, .div4_counts_out);
`default_nettype wire

/* File: tb/clkd_host.sv */
// Host model driving the serial control port
`timescale 1ns/100ps
`default_nettype none
module clkd_host
(
	// Clock
	input  wire logic clk_in,
	// Frame format
	input  wire logic lng_in,
	// Serial port
	output var  logic sclk_out,
	output var  logic cs_n_out,
	output var  logic dat_out,
	input  wire logic rbit_in
);
	initial
	begin
		sclk_out = 1'b0;
		cs_n_out = 1'b1;
		dat_out = 1'b0;
	end
	// One frame: instruction in either length and one data byte
	task automatic xfer(input logic rd, input logic [12:0] a, input logic [7:0] d,
		input logic lsb, output logic [7:0] q);
		logic [23:0] s;
		int ni;
		int i;
		q = 8'h00;
		@(posedge clk_in) cs_n_out <= 1'b0;
		// Short frames carry five address bits and end a byte early
		ni = lng_in ? 16 : 8;
		s = lng_in ? {rd, 2'b00, a, d} : {rd, 2'b00, a[4:0], d, 8'h00};
		for (i = 0; i < ni + 8; i++)
		begin
			repeat (3) @(posedge clk_in);
			sclk_out <= 1'b0;
			// Released line toggles so a stale bit is never read as data
			dat_out <= (rd && i >= ni) ? ~dat_out
				: s[lsb ? (i < ni ? i + 24 - ni : i + 16 - 2 * ni) : 23 - i];
			repeat (3) @(posedge clk_in);
			sclk_out <= 1'b1;
			if (i >= ni)
				q = lsb ? {rbit_in, q[7:1]} : {q[6:0], rbit_in};
		end
		repeat (3) @(posedge clk_in);
		sclk_out <= 1'b0;
		repeat (3) @(posedge clk_in);
		cs_n_out <= 1'b1;
		repeat (4) @(posedge clk_in);
	endtask
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
// Self-checking bench for the clock distribution control bank
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic       clk_in = 1'b0;
	logic       nrst_in = 1'b0;
	logic       bidir = 1'b0;
	logic       lmode = 1'b1;
	logic [7:0] q;
	int         n_fail = 0;
	int         cmp_count = 0;
	wire        sclk, cs_n, hd, dq, dq_oe, so, so_oe, srst, lng, lsb, byp, pd;
	wire  [2:0] ramp, cap, sync;
	wire  [7:0] d4c, d2p, d3c, d3p, d4p;
	wire        sdio_w = dq_oe ? dq : hd;
	wire        so_w = so_oe ? so : ~so;
	always #10 clk_in = ~clk_in;
	clkd_host host (.clk_in(clk_in), .lng_in(lmode), .sclk_out(sclk), .cs_n_out(cs_n), .dat_out(hd),
		.rbit_in(bidir ? sdio_w : so_w));
	clkd_ctrl uut (.clk_in(clk_in), .nrst_in(nrst_in), .ce_in(1'b1), .sclk_in(sclk),
		.cs_n_in(cs_n), .sdio_in(sdio_w), .sdio_out(dq), .sdio_oe_out(dq_oe),
		.serial_out_pin_out(so), .serial_out_pin_oe_out(so_oe), .soft_reset_out(srst),
		.long_instr_out(lng), .lsb_first_out(lsb), .adjustable_delay_output_bypass_out(byp),
		.ramp_current_out(ramp), .ramp_capacitor_out(cap), .div2_phase_out(d2p), .div3_counts_out(d3c),
		.div3_phase_out(d3p), .div4_counts_out(d4c), .div4_phase_out(d4p), .sync_cfg_out(sync),
		.power_down_all_reference_out(pd));
	task chk(input logic [7:0] g, input logic [7:0] e);
		cmp_count++;
		if (g !== e)
		begin
			n_fail++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task wr(input logic [12:0] a, input logic [7:0] d, input logic l);
		host.xfer(1'b0, a, d, l, q);
	endtask
	task rd(input logic [12:0] a, input logic [7:0] e, input logic l);
		host.xfer(1'b1, a, 8'h00, l, q);
		chk(q, e);
	endtask
	task final_report;
		$display("checks=%0d mismatches=%0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial
	begin
		#500000;
		n_fail++;
		final_report;
	end
	initial
	begin
		repeat (20) @(posedge clk_in);
		nrst_in <= 1'b1;
		@(posedge clk_in);
		chk({4'h0, srst, lng, lsb, byp}, 8'h05);
		chk(d4c, 8'h11);
		rd(13'h0000, 8'h10, 1'b0);
		wr(13'h0000, 8'h00, 1'b0);
		lmode = 1'b0;
		chk({7'h00, lng}, 8'h00);
		rd(13'h0000, 8'h00, 1'b0);
		wr(13'h0000, 8'h10, 1'b0);
		lmode = 1'b1;
		chk({7'h00, lng}, 8'h01);
		wr(13'h0035, 8'h05, 1'b0);
		chk({5'h00, ramp}, 8'h00);
		rd(13'h0035, 8'h05, 1'b0);
		wr(13'h005A, 8'h01, 1'b0);
		chk({5'h00, ramp}, 8'h05);
		rd(13'h005A, 8'h00, 1'b0);
		rd(13'h0001, 8'h00, 1'b0);
		wr(13'h0000, 8'h50, 1'b0);
		chk({7'h00, lsb}, 8'h01);
		wr(13'h0052, 8'hA5, 1'b1);
		rd(13'h0052, 8'hA5, 1'b1);
		wr(13'h0000, 8'h10, 1'b1);
		chk({7'h00, lsb}, 8'h00);
		wr(13'h0000, 8'h90, 1'b0);
		bidir = 1'b1;
		rd(13'h0052, 8'hA5, 1'b0);
		wr(13'h0000, 8'h10, 1'b0);
		bidir = 1'b0;
		wr(13'h005A, 8'h01, 1'b0);
		chk(d4c, 8'hA5);
		wr(13'h0034, 8'h00, 1'b0);
		wr(13'h004F, 8'h81, 1'b0);
		wr(13'h0050, 8'h23, 1'b0);
		wr(13'h0051, 8'h45, 1'b0);
		wr(13'h0053, 8'h67, 1'b0);
		wr(13'h0058, 8'h0D, 1'b0);
		wr(13'h0035, 8'h3A, 1'b0);
		chk(d2p, 8'h00);
		wr(13'h005A, 8'h01, 1'b0);
		chk({7'h00, byp}, 8'h00);
		chk(d2p, 8'h81);
		chk(d3c, 8'h23);
		chk(d3p, 8'h45);
		chk(d4p, 8'h67);
		chk({4'h0, pd, sync}, 8'h0D);
		chk({2'h0, cap, ramp}, 8'h3A);
		wr(13'h0000, 8'h30, 1'b0);
		chk({srst, byp, ramp, 3'h0}, 8'hC0);
		chk(d4c, 8'h11);
		chk(d2p, 8'h00);
		chk(d3c, 8'h00);
		chk(d3p, 8'h00);
		chk(d4p, 8'h00);
		chk({4'h0, pd, sync}, 8'h00);
		chk({5'h00, cap}, 8'h00);
		wr(13'h0052, 8'h22, 1'b0);
		chk({7'h00, srst}, 8'h01);
		wr(13'h0000, 8'h10, 1'b0);
		rd(13'h0052, 8'h11, 1'b0);
		final_report;
	end
endmodule
`default_nettype wire
